/* File: src/dma_chain_pkg.sv */
// Package for the descriptor chaining control block of the DMA engine.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package dma_chain_pkg;

    // ==========================================================
    // Sizes.
    localparam int NUM_CH = 6;

    // ==========================================================
    // Register byte offsets; pointer and channel status repeat every word.
    localparam logic [7:0] ADDR_PTR_BASE = 8'h00;
    localparam logic [7:0] ADDR_GCTRL = 8'h20;
    localparam logic [7:0] ADDR_BELL = 8'h24;
    localparam logic [7:0] ADDR_PEND = 8'h28;
    localparam logic [7:0] ADDR_CSR_BASE = 8'h40;

    // ==========================================================
    // Global control fields.
    localparam int GC_PM = 8;
    localparam int GC_HLT = 3;
    localparam int GC_AR = 2;
    localparam int GC_EN = 0;
    localparam logic [1:0] PM_ROUND = 2'h3;

    // Channel status register bit positions.
    localparam int CS_NO_DESCRIPTOR_SELECT = 31;
    localparam int CS_INV = 6;
    localparam int CS_AR = 4;
    localparam int CS_TT = 3;
    localparam int CS_HLT = 2;
    localparam int CS_CT = 1;
    localparam int CS_CTE = 0;

    // Positions inside the packed per-channel status vector.
    localparam int CSI_CTE = 0;
    localparam int CSI_CT = 1;
    localparam int CSI_HLT = 2;
    localparam int CSI_TT = 3;
    localparam int CSI_AR = 4;
    localparam int CSI_INV = 5;
    localparam int CSI_NO_DESCRIPTOR_SELECT = 6;

    // Command word and offset/count word fields.
    localparam int DES_V = 4;
    localparam int DES_VM = 3;
    localparam int DES_VIE = 2;
    localparam int DES_TIE = 1;
    localparam int DES_LINK = 0;
    localparam int DES_OFF_LSB = 24;
    localparam int DES_CNT_W = 24;

    // Reset value of every register of the block.
    localparam logic [31:0] RST_VALUE = 32'h0000_0000;

    // Fixed orders, highest priority at position 0, one row per mode.
    localparam logic [2:0][5:0][2:0] PRIO_ORDER = {
        {3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h2},
        {3'h5, 3'h4, 3'h1, 3'h3, 3'h2, 3'h0},
        {3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}};

    // Descriptor engine states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_FETCH = 3'h1,
        S_CHECK = 3'h3,
        S_WAIT = 3'h2,
        S_MOVE = 3'h6,
        S_WBACK = 3'h7,
        S_DONE = 3'h5
    } state_type;

endpackage

/* File: src/dma_channel_arbiter.sv */
// Channel arbiter: picks one requesting channel by the priority mode.
// Assumes the caller keeps the round robin history and is combinational.
`timescale 1ns/10ps
module dma_channel_arbiter (
    input wire logic [dma_chain_pkg::NUM_CH-1:0] req_i,
    input wire logic [1:0] mode_i,
    input wire logic [1:0] rr_lo_i,
    input wire logic rr_hi_i,
    output logic grant_valid_o,
    output logic [2:0] grant_o
);
    import dma_chain_pkg::*;

    // ==========================================================
    // Selection. Scans run from lowest to highest priority so that the
    // last hit wins; the low group always beats the high group.
    always_comb begin
        logic [1:0] lo;
        logic hi;
        lo = 2'h0;
        hi = 1'b0;
        grant_valid_o = 1'b0;
        grant_o = 3'h0;
        if (mode_i != PM_ROUND) begin
            for (int i = NUM_CH - 1; i >= 0; i--) begin
                if (req_i[PRIO_ORDER[mode_i][i]]) begin
                    grant_valid_o = 1'b1;
                    grant_o = PRIO_ORDER[mode_i][i];
                end
            end
        end else begin
            for (int i = 2; i >= 1; i--) begin
                hi = rr_hi_i + 1'(i);
                if (req_i[{2'h2, hi}]) begin
                    grant_valid_o = 1'b1;
                    grant_o = {2'h2, hi};
                end
            end
            for (int i = 4; i >= 1; i--) begin
                lo = rr_lo_i + 2'(i);
                if (req_i[{1'b0, lo}]) begin
                    grant_valid_o = 1'b1;
                    grant_o = {1'b0, lo};
                end
            end
        end
    end

endmodule

/* File: src/dma_descriptor_chain_control.sv */
// Descriptor chaining control of a six channel DMA engine.
// Assumes a Wishbone master for registers, a memory port that answers
// with ack or err, a data mover that reports done, error or halt.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
module dma_descriptor_chain_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_adr_o,
    output logic [31:0] mem_dat_o,
    input wire logic [31:0] mem_dat_i,
    input wire logic mem_ack_i,
    input wire logic mem_err_i,
    output logic mover_start_o,
    output logic [2:0] mover_ch_o,
    output logic [31:0] mover_cmd_o,
    output logic [31:0] mover_src_o,
    output logic [31:0] mover_dst_o,
    output logic [dma_chain_pkg::DES_CNT_W-1:0] mover_count_o,
    input wire logic mover_done_i,
    input wire logic mover_err_i,
    input wire logic mover_halt_i,
    input wire logic [dma_chain_pkg::NUM_CH-1:0] periph_req_i,
    output logic irq_o
);
    import dma_chain_pkg::*;

    // ==========================================================
    // State of the whole block.
    typedef struct packed {
        state_type state;
        logic [2:0] ch;
        logic [1:0] word;
        logic [3:0][31:0] desc;
        logic [NUM_CH-1:0][27:0] ptr;
        logic [NUM_CH-1:0][6:0] cs;
        logic [1:0] pm;
        logic ghlt;
        logic gar;
        logic gen;
        logic [NUM_CH-1:0] bell;
        logic [NUM_CH-1:0] pend;
        logic [NUM_CH-1:0] irq_en;
        logic [NUM_CH-1:0] req_s1;
        logic [NUM_CH-1:0] req_s2;
        logic [1:0] rr_lo;
        logic rr_hi;
        logic ack;
        logic [31:0] rdata;
        logic mreq;
        logic mwe;
        logic [31:0] madr;
        logic [31:0] mdat;
        logic irq;
    } regs_type;

    regs_type r;
    regs_type n;
    logic [NUM_CH-1:0] arb_req;
    logic grant_valid;
    logic [2:0] grant;
    logic bus_wr;
    logic bell_hit;

    // ==========================================================
    // Register read mux; unmapped words read as zero.
    function automatic logic [31:0] reg_read(regs_type s, logic [7:0] a);
        logic [2:0] k;
        logic [31:0] v;
        k = a[4:2];
        v = RST_VALUE;
        if (a[7:5] == ADDR_PTR_BASE[7:5] && k < 3'(NUM_CH)) begin
            v = {s.ptr[k], 4'h0};
        end else if (a[7:5] == ADDR_CSR_BASE[7:5] && k < 3'(NUM_CH)) begin
            {v[CS_NO_DESCRIPTOR_SELECT], v[CS_INV], v[CS_AR], v[CS_TT], v[CS_HLT], v[CS_CT],
             v[CS_CTE]} = s.cs[k];
        end else if (a == ADDR_GCTRL) begin
            {v[GC_PM+1:GC_PM], v[GC_HLT], v[GC_AR], v[GC_EN]} =
                {s.pm, s.ghlt, s.gar, s.gen};
        end else if (a == ADDR_BELL) begin
            v[NUM_CH-1:0] = s.bell;
        end else if (a == ADDR_PEND) begin
            v[NUM_CH-1:0] = s.pend;
        end
        return v;
    endfunction

    // ==========================================================
    // Channels eligible for a fresh descriptor fetch. A channel that
    // stopped on an error stays out until software clears its flags.
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            arb_req[i] = r.bell[i] & r.cs[i][CSI_CTE] & r.gen
                & ~r.cs[i][CSI_NO_DESCRIPTOR_SELECT]
                & ~r.cs[i][CSI_INV] & ~r.cs[i][CSI_AR]
                & ~r.cs[i][CSI_HLT];
        end
    end

    dma_channel_arbiter arbiter (
        .req_i(arb_req),
        .mode_i(r.pm),
        .rr_lo_i(r.rr_lo),
        .rr_hi_i(r.rr_hi),
        .grant_valid_o(grant_valid),
        .grant_o(grant)
    );
    // Bus write strobe and doorbell hit, both in the cycle before wb_ack_o rises.
    assign bus_wr = wb_cyc_i & wb_stb_i & ~r.ack & wb_we_i;
    assign bell_hit = bus_wr && wb_adr_i == ADDR_BELL;
    // Start the mover only with a synchronised request and both enables.
    assign mover_start_o = r.state == S_WAIT && r.req_s2[r.ch]
        && r.gen && r.cs[r.ch][CSI_CTE];

    // ==========================================================
    // Next state: bus writes first, hardware sets afterwards so a set
    // always beats a clear written in the same cycle.
    always_comb begin
        logic [31:0] mask;
        logic [31:0] m;
        logic [2:0] k;
        logic [NUM_CH-1:0] bell_wr;
        logic err_ev;
        logic [31:0] d0;
        mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        m = (reg_read(r, wb_adr_i) & ~mask) | (wb_dat_i & mask);
        k = wb_adr_i[4:2];
        bell_wr = '0;
        err_ev = 1'b0;
        d0 = r.desc[0];
        n = r;
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        n.rdata = reg_read(r, wb_adr_i);
        n.req_s1 = periph_req_i;
        n.req_s2 = r.req_s1;
        // Register writes under byte enables.
        if (bus_wr) begin
            if (wb_adr_i[7:5] == ADDR_PTR_BASE[7:5] && k < 3'(NUM_CH)) begin
                n.ptr[k] = m[31:4];
            end else if (wb_adr_i[7:5] == ADDR_CSR_BASE[7:5]
                         && k < 3'(NUM_CH)) begin
                n.cs[k] = {m[CS_NO_DESCRIPTOR_SELECT], m[CS_INV], m[CS_AR], m[CS_TT],
                           m[CS_HLT], m[CS_CT], m[CS_CTE]};
            end else if (wb_adr_i == ADDR_GCTRL) begin
                n.pm = m[GC_PM+1:GC_PM];
                {n.ghlt, n.gar, n.gen} = {m[GC_HLT], m[GC_AR], m[GC_EN]};
            end else if (wb_adr_i == ADDR_PEND) begin
                n.pend = m[NUM_CH-1:0];
            end else if (wb_adr_i == ADDR_BELL) begin
                bell_wr = wb_dat_i[NUM_CH-1:0] & mask[NUM_CH-1:0];
            end
        end
        // Descriptor engine; one channel is served at a time, so a bell
        // rung for the busy channel simply stays set.
        unique case (r.state)
            S_IDLE: begin
                if (grant_valid) begin
                    n.ch = grant;
                    n.word = 2'h0;
                    n.bell[grant] = 1'b0;
                    n.state = S_FETCH;
                    n.rr_hi = grant[2] ? grant[0] : r.rr_hi;
                    n.rr_lo = grant[2] ? r.rr_lo : grant[1:0];
                end
            end
            S_FETCH: begin
                if (r.mreq) begin
                    if (mem_err_i) begin
                        err_ev = 1'b1;
                    end else if (mem_ack_i) begin
                        n.mreq = 1'b0;
                        n.desc[r.word] = mem_dat_i;
                        n.word = r.word + 2'h1;
                        if (r.word == 2'h3) begin
                            n.state = S_CHECK;
                        end
                    end
                end else begin
                    n.mreq = 1'b1;
                    n.mwe = 1'b0;
                    n.madr = {r.ptr[r.ch], r.word, 2'h0};
                end
            end
            S_CHECK: begin
                if (!d0[DES_V] && d0[DES_VM]) begin
                    n.cs[r.ch][CSI_INV] = 1'b1;
                    n.pend[r.ch] = 1'b1;
                    n.irq_en[r.ch] = r.irq_en[r.ch] | d0[DES_VIE];
                    n.state = S_IDLE;
                end else begin
                    n.state = S_WAIT;
                end
            end
            S_WAIT: begin
                if (mover_start_o) begin
                    n.state = S_MOVE;
                end
            end
            S_MOVE: begin
                if (mover_err_i) begin
                    err_ev = 1'b1;
                end else if (mover_halt_i) begin
                    n.cs[r.ch][CSI_HLT] = 1'b1;
                    n.ghlt = 1'b1;
                    n.pend[r.ch] = 1'b1;
                    n.irq_en[r.ch] = 1'b1;
                    n.state = S_IDLE;
                end else if (mover_done_i) begin
                    n.state = d0[DES_VM] ? S_WBACK : S_DONE;
                end
            end
            S_WBACK: begin
                if (r.mreq) begin
                    if (mem_err_i) begin
                        err_ev = 1'b1;
                    end else if (mem_ack_i) begin
                        n.mreq = 1'b0;
                        n.state = S_DONE;
                    end
                end else begin
                    n.mreq = 1'b1;
                    n.mwe = 1'b1;
                    n.madr = {r.ptr[r.ch], 4'h0};
                    n.mdat = d0 & ~(32'h0000_0001 << DES_V);
                end
            end
            S_DONE: begin
                n.pend[r.ch] = 1'b1;
                n.irq_en[r.ch] = r.irq_en[r.ch] | d0[DES_TIE];
                if (d0[DES_LINK]) begin
                    n.cs[r.ch][CSI_CT] = 1'b1;
                    n.ptr[r.ch][7:0] = r.desc[3][31:DES_OFF_LSB];
                    n.word = 2'h0;
                    n.state = S_FETCH;
                end else begin
                    n.cs[r.ch][CSI_TT] = 1'b1;
                    n.state = S_IDLE;
                end
            end
            default: begin
                n.state = S_IDLE;
            end
        endcase
        // Address error: stop, flag both levels, interrupt regardless.
        if (err_ev) begin
            n.cs[r.ch][CSI_AR] = 1'b1;
            n.gar = 1'b1;
            n.pend[r.ch] = 1'b1;
            n.irq_en[r.ch] = 1'b1;
            n.mreq = 1'b0;
            n.state = S_IDLE;
        end
        // Software set of the doorbell beats the hardware clear.
        n.bell = n.bell | bell_wr;
        n.irq_en = n.irq_en & n.pend;
        n.irq = |(n.pend & n.irq_en);
    end
    // Register update.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    // Outputs straight from flip-flops.
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdata;
    assign mem_req_o = r.mreq;
    assign mem_we_o = r.mwe;
    assign mem_adr_o = r.madr;
    assign mem_dat_o = r.mdat;
    assign mover_ch_o = r.ch;
    assign mover_cmd_o = r.desc[0];
    assign mover_src_o = r.desc[1];
    assign mover_dst_o = r.desc[2];
    assign mover_count_o = r.desc[3][DES_CNT_W-1:0];
    assign irq_o = r.irq;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ptr_ignored: assert property (
        r.state == S_IDLE && grant_valid |-> !r.cs[grant][CSI_NO_DESCRIPTOR_SELECT])
        else $error("Descriptor fetch granted to a no-descriptor channel.");
    a_next_addr: assert property (
        r.state == S_DONE && r.desc[0][DES_LINK] && !bus_wr
        |=> r.ptr[$past(r.ch)][7:0] == $past(r.desc[3][31:24]))
        else $error("Linked offset not loaded into the pointer.");
    a_fetch_walk: assert property (
        mem_req_o && !mem_we_o |-> mem_adr_o == {r.ptr[r.ch], r.word, 2'h0})
        else $error("Descriptor word fetched from a wrong address.");
    a_prio_fixed: assert property (
        r.state == S_IDLE && grant_valid && r.pm == 2'h0
        |-> (arb_req & 6'((6'h01 << grant) - 6'h01)) == 6'h00)
        else $error("Fixed order did not pick the lowest channel.");
    a_halt_global: assert property (
        r.state == S_MOVE && mover_halt_i && !mover_err_i
        |=> r.ghlt && r.state == S_IDLE)
        else $error("Halt did not set the global halt flag.");
    a_err_global: assert property (
        r.state == S_FETCH && r.mreq && mem_err_i
        |=> r.gar && r.pend[$past(r.ch)] && irq_o)
        else $error("Address error not flagged or not interrupting.");
    a_enable_gate: assert property (
        r.state == S_IDLE && !r.gen |=> r.state == S_IDLE)
        else $error("Descriptor fetch began while disabled.");
    a_bell_clear: assert property (
        r.state == S_IDLE && grant_valid && !bell_hit
        |=> !r.bell[$past(grant)] && r.state == S_FETCH)
        else $error("Doorbell not cleared when the fetch began.");
    a_invalid_stop: assert property (
        r.state == S_CHECK && !r.desc[0][DES_V] && r.desc[0][DES_VM]
        |=> r.state == S_IDLE && r.cs[$past(r.ch)][CSI_INV])
        else $error("Invalid descriptor not stopped.");
    a_wait_request: assert property (
        mover_start_o |-> r.req_s2[r.ch] ##1 r.state == S_MOVE)
        else $error("Transfer started without a peripheral request.");
    a_writeback_v: assert property (
        mem_req_o && mem_we_o |-> !mem_dat_o[DES_V] && mem_adr_o[3:0] == 4'h0)
        else $error("Write-back kept the valid bit set.");
    a_done_flags: assert property (
        r.state == S_DONE && !r.desc[0][DES_LINK]
        |=> r.cs[$past(r.ch)][CSI_TT] && r.state == S_IDLE)
        else $error("Unlinked finish did not set transfer terminate.");
    a_chain_next: assert property (
        r.state == S_DONE && r.desc[0][DES_LINK]
        |=> r.state == S_FETCH && r.word == 2'h0)
        else $error("Linked descriptor did not chain to the next one.");

endmodule

/* File: tb/dma_descriptor_chain_control_bench.sv */
// Self-checking bench for the descriptor chaining control block.
// Assumes the memory model file and the design package are compiled first.
`timescale 1ns/10ps
module dma_descriptor_chain_control_bench;
    import dma_chain_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, done = 0, halt = 0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0, rdat, rd_o, mdat, madr, mwd, mcmd, msrc, mdst;
    logic [31:0] r = 32'h0000_d013;
    logic ack, mreq, mwe, mack, merr, start, irq;
    logic [2:0] lat = '0, mch;
    logic [5:0] preq = '0;
    logic mverr = 1'b0;
    logic [23:0] mcnt;
    logic [127:0] mv_got;
    logic [119:0] exp_q[$];
    int fail_count = 0, n_checks = 0, cycles = 0, starts = 0;

    always #2 clk_i = ~clk_i;

    dma_descriptor_chain_control uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack),
        .mem_req_o(mreq), .mem_we_o(mwe), .mem_adr_o(madr), .mem_dat_o(mwd),
        .mem_dat_i(mdat), .mem_ack_i(mack), .mem_err_i(merr),
        .mover_start_o(start), .mover_ch_o(mch), .mover_cmd_o(mcmd),
        .mover_src_o(msrc), .mover_dst_o(mdst), .mover_count_o(mcnt),
        .mover_done_i(done), .mover_err_i(mverr), .mover_halt_i(halt),
        .periph_req_i(preq), .irq_o(irq));
    dma_mem_model u_mem (.clk_i(clk_i), .req_i(mreq), .we_i(mwe),
        .adr_i(madr), .dat_i(mwd), .lat_i(lat), .dat_o(mdat), .ack_o(mack),
        .err_o(merr));

    // ==========================================================
    // Helpers
    // Captures every mover start and cuts a hung run short.
    always @(posedge clk_i) begin
        cycles++;
        if (start === 1'b1) begin
            starts++;
            mv_got = {5'h00, mch, mcmd, msrc, mdst, mcnt};
        end
        if (cycles == 40000) begin
            fail_count++;
            summarize();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = rd_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask

    // Places a descriptor with random addresses and queues its expectation.
    task automatic setd(input logic [7:0] i, input logic [31:0] c,
                        input logic [7:0] nxt);
        logic [31:0] s;
        r = lfsr(r);
        s = r;
        r = lfsr(r);
        lat <= r[2:0];
        u_mem.m[i] = c;
        u_mem.m[i + 8'h01] = s;
        u_mem.m[i + 8'h02] = ~r;
        u_mem.m[i + 8'h03] = {nxt, r[23:0]};
        exp_q.push_back({c, s, ~r, r[23:0]});
    endtask

    // Waits for a mover start, compares it, then ends it with done (0),
    // halt (1) or a mover error (2).
    task automatic mv(input logic [2:0] ch, input logic [1:0] k);
        int s0;
        s0 = starts;
        repeat (400) if (starts == s0) @(posedge clk_i);
        chk(mv_got, {5'h00, ch, exp_q.pop_front()});
        @(posedge clk_i);
        done <= k == 2'h0;
        halt <= k == 2'h1;
        mverr <= k == 2'h2;
        @(posedge clk_i);
        halt <= 1'b0;
        done <= 1'b0;
        mverr <= 1'b0;
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 96; a += 4) rd(8'(a), 32'h0000_0000);
        for (int p = 0; p < 4; p++) begin
            wb(1'b1, ADDR_GCTRL, 32'hffff_fc00 | (p << GC_PM));
            rd(ADDR_GCTRL, p << GC_PM);
        end
        // Linked chain on channel 0, rung while the global enable is off.
        setd(8'h00, 32'h0000_001b, 8'h10);
        setd(8'h40, 32'h0000_0002, 8'h00);
        wb(1'b1, ADDR_PTR_BASE, 32'h0000_1000);
        wb(1'b1, ADDR_CSR_BASE, 32'h0000_0001);
        preq <= 6'h01;
        wb(1'b1, ADDR_BELL, 32'h0000_0001);
        repeat (60) @(posedge clk_i);
        chk(starts, 0);
        wb(1'b1, ADDR_GCTRL, 32'h0000_0301);
        mv(3'h0, 1'b0);
        rd(ADDR_BELL, 32'h0000_0000);
        mv(3'h0, 1'b0);
        repeat (40) @(posedge clk_i);
        rd(ADDR_PTR_BASE, 32'h0000_1100);
        rd(ADDR_CSR_BASE, 32'h0000_000b);
        rd(ADDR_PEND, 32'h0000_0001);
        chk(irq, 1'b1);
        chk(u_mem.m[0], 32'h0000_000b);
        chk(u_mem.m[8'h40], 32'h0000_0002);
        wb(1'b1, ADDR_PEND, 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        // Channel 1 fetches a descriptor whose valid flag is clear.
        u_mem.m[8'h80] = 32'h0000_000c;
        wb(1'b1, ADDR_PTR_BASE | 8'h04, 32'h0000_1200);
        wb(1'b1, ADDR_CSR_BASE | 8'h04, 32'h0000_0001);
        wb(1'b1, ADDR_BELL, 32'h0000_0002);
        repeat (60) @(posedge clk_i);
        rd(ADDR_CSR_BASE | 8'h04, 32'h0000_0041);
        rd(ADDR_PEND, 32'h0000_0002);
        chk(starts, 2);
        // Channel 2 points into absent memory.
        wb(1'b1, ADDR_PTR_BASE | 8'h08, 32'h8000_0000);
        wb(1'b1, ADDR_CSR_BASE | 8'h08, 32'h0000_0001);
        wb(1'b1, ADDR_BELL, 32'h0000_0004);
        repeat (60) @(posedge clk_i);
        rd(ADDR_CSR_BASE | 8'h08, 32'h0000_0011);
        rd(ADDR_GCTRL, 32'h0000_0305);
        rd(ADDR_PEND, 32'h0000_0006);
        chk(irq, 1'b1);
        // Channels 3, 4 and 5 rung together in fixed order; channel 3 is
        // halted, 4 hits a mover error, 5 has no descriptors and stays rung.
        setd(8'hc0, 32'h0000_0018, 8'h00);
        setd(8'h20, 32'h0000_0018, 8'h00);
        wb(1'b1, ADDR_PTR_BASE | 8'h0c, 32'h0000_1300);
        wb(1'b1, ADDR_PTR_BASE | 8'h10, 32'h0000_1080);
        wb(1'b1, ADDR_CSR_BASE | 8'h0c, 32'h0000_0001);
        wb(1'b1, ADDR_CSR_BASE | 8'h10, 32'h0000_0001);
        wb(1'b1, ADDR_CSR_BASE | 8'h14, 32'h8000_0001);
        wb(1'b1, ADDR_GCTRL, 32'h0000_0001);
        preq <= 6'h18;
        wb(1'b1, ADDR_BELL, 32'h0000_0038);
        mv(3'h3, 2'h1);
        mv(3'h4, 2'h2);
        repeat (20) @(posedge clk_i);
        rd(ADDR_GCTRL, 32'h0000_000d);
        rd(ADDR_CSR_BASE | 8'h0c, 32'h0000_0005);
        rd(ADDR_CSR_BASE | 8'h10, 32'h0000_0011);
        rd(ADDR_BELL, 32'h0000_0020);
        rd(ADDR_PEND, 32'h0000_001e);
        chk(starts, 4);
        chk(irq, 1'b1);
        summarize();
    end
endmodule

/* File: tb/dma_mem_model.sv */
// Memory model that answers the descriptor fetch and write-back port.
// Assumes one outstanding request; the bench sets the answer latency.
`timescale 1ns/10ps
module dma_mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [2:0] lat_i,
    output logic [31:0] dat_o = 32'h5a5a_a5a5,
    output logic ack_o = 1'b0,
    output logic err_o = 1'b0
);
    logic [31:0] m [256];
    int w = 0;

    // ==========================================================
    // Answer logic
    // Answers after lat_i waiting cycles; the upper half of the map is
    // absent, and read data toggles whenever it is not being answered.
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        err_o <= 1'b0;
        dat_o <= ~dat_o;
        if (req_i && !ack_o && !err_o) begin
            if (w < lat_i) begin
                w++;
            end else begin
                w = 0;
                if (adr_i[31]) begin
                    err_o <= 1'b1;
                end else begin
                    ack_o <= 1'b1;
                    dat_o <= m[adr_i[9:2]];
                    if (we_i) m[adr_i[9:2]] <= dat_i;
                end
            end
        end
    end
endmodule
